// ### gain_code_host.v
// host controller driving the step-gain amplifier control pins
`timescale 1ns/10ps
`include "gain_ctrl_defs.vh"
module gain_code_host (
  input  wire                mclk,
  input  wire                sys_rst,
  input  wire                serial_mode,
  input  wire                req_valid,
  input  wire [`CODE_W-1:0]  req_code,
  output reg                 req_ready,
  output reg                 done,
  output reg                 interface_select,
  output reg                 load_strobe,
  output reg                 gain_code_msb_pin,
  output reg                 gain_code_bit2_pin,
  output reg                 gain_code_or_serial_clock_pin_a,
  output reg                 gain_code_lsb_or_serial_data_pin
);
  localparam ST_IDLE       = 3'h0;
  localparam ST_PAR_SET    = 3'h1;
  localparam ST_PAR_FALL   = 3'h2;
  localparam ST_SER_LOW    = 3'h3;
  localparam ST_SER_CLK_LO = 3'h4;
  localparam ST_SER_CLK_HI = 3'h5;
  localparam ST_SER_LATCH  = 3'h6;
  localparam ST_SER_END    = 3'h7;

  reg  [2:0]         state_reg;
  reg  [2:0]         state_next;
  reg  [`CODE_W-1:0] word_reg;
  reg  [`CODE_W-1:0] word_next;
  reg  [2:0]         bits_reg;
  reg  [2:0]         bits_next;
  reg                mode_reg;
  reg                mode_next;
  reg                req_ready_next;
  reg                done_next;
  reg                interface_select_next;
  reg                load_strobe_next;
  reg  [`CODE_W-1:0] pins_next;
  wire [`CODE_W-1:0] pins_now;
  wire [2:0]         bits_inc;
  wire               tick;
  wire               busy;
  wire               take;

  // pin order on the link: msb down to lsb
  assign pins_now = {gain_code_msb_pin, gain_code_bit2_pin, gain_code_or_serial_clock_pin_a,
                     gain_code_lsb_or_serial_data_pin};
  assign busy     = (state_reg != ST_IDLE);
  assign take     = req_valid && req_ready;
  assign bits_inc = bits_reg + `BIT_STEP;

  // divider runs only inside a frame so the first tick lands a fixed time after the take
  half_bit_divider u_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .run     (busy),
    .tick    (tick)
  );

  always @* begin
    state_next            = state_reg;
    word_next             = word_reg;
    bits_next             = bits_reg;
    mode_next             = mode_reg;
    req_ready_next        = 1'b0;
    done_next             = 1'b0;
    interface_select_next = interface_select;
    load_strobe_next      = load_strobe;
    pins_next             = pins_now;
    case (state_reg)
      ST_IDLE: begin
        // ready drops in the take cycle so a held request is not taken twice
        req_ready_next = !take;
        if (take) begin
          word_next             = req_code;
          mode_next             = serial_mode;
          interface_select_next = serial_mode;
          bits_next             = `BITS_NONE;
          if (serial_mode) begin
            load_strobe_next = 1'b0;
            state_next       = ST_SER_LOW;
          end else begin
            load_strobe_next = 1'b1;
            state_next       = ST_PAR_SET;
          end
        end
      end
      ST_PAR_SET: begin
        pins_next = word_reg;
        if (tick) begin
          state_next = ST_PAR_FALL;
        end
      end
      ST_PAR_FALL: begin
        // word held across the fall for setup and hold
        if (tick) begin
          load_strobe_next = 1'b0;
          state_next       = ST_SER_END;
        end
      end
      ST_SER_LOW: begin
        pins_next[`PIN_CLK] = 1'b0;
        if (tick) begin
          state_next = ST_SER_CLK_LO;
        end
      end
      ST_SER_CLK_LO: begin
        // msb first so the first bit ends in the top position
        pins_next[`PIN_DATA] = word_reg[`CODE_W-1];
        if (tick) begin
          pins_next[`PIN_CLK] = 1'b1;
          state_next          = ST_SER_CLK_HI;
        end
      end
      ST_SER_CLK_HI: begin
        if (tick) begin
          pins_next[`PIN_CLK] = 1'b0;
          word_next           = {word_reg[`CODE_W-2:0], 1'b0};
          bits_next           = bits_inc;
          if (bits_inc == `SER_BITS) begin
            state_next = ST_SER_LATCH;
          end else begin
            state_next = ST_SER_CLK_LO;
          end
        end
      end
      ST_SER_LATCH: begin
        // clock idle low before the rise so no extra shift is seen
        if (tick) begin
          load_strobe_next = 1'b1;
          state_next       = ST_SER_END;
        end
      end
      ST_SER_END: begin
        if (tick) begin
          // serial: strobe back low so the next word shifts without a gain change
          if (mode_reg) begin
            load_strobe_next = 1'b0;
          end
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // frame control state
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      word_reg  <= `CODE_MIN;
      bits_reg  <= `BITS_NONE;
      mode_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      word_reg  <= word_next;
      bits_reg  <= bits_next;
      mode_reg  <= mode_next;
    end
  end

  // strobe starts high with the minimum code so a parallel device powers up defined
  // a cut frame reloads the device latch: reset drives strobe high in parallel mode with the minimum code, giving minimum gain
  always @(posedge mclk) begin
    if (sys_rst) begin
      req_ready        <= 1'b0;
      done             <= 1'b0;
      interface_select <= 1'b0;
      load_strobe      <= 1'b1;
      {gain_code_msb_pin, gain_code_bit2_pin, gain_code_or_serial_clock_pin_a,
       gain_code_lsb_or_serial_data_pin} <= `CODE_MIN;
    end else begin
      req_ready        <= req_ready_next;
      done             <= done_next;
      interface_select <= interface_select_next;
      load_strobe      <= load_strobe_next;
      {gain_code_msb_pin, gain_code_bit2_pin, gain_code_or_serial_clock_pin_a,
       gain_code_lsb_or_serial_data_pin} <= pins_next;
    end
  end
endmodule // gain_code_host

// ### gain_code_host_properties.sv
// pin timing checker for the gain code host
`timescale 1ns/10ps
module gain_code_host_properties (
  input wire mclk,
  input wire sys_rst,
  input wire serial_mode,
  input wire req_valid,
  input wire req_ready,
  input wire done,
  input wire interface_select,
  input wire load_strobe,
  input wire gain_code_or_serial_clock_pin_a,
  input wire gain_code_lsb_or_serial_data_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire s = interface_select;
  wire k = gain_code_or_serial_clock_pin_a;
  wire t = req_valid && req_ready;
  reg       k_reg;
  reg [2:0] cnt_reg;
  // rises counted per frame, cleared while strobe high
  always @(posedge mclk) begin
    k_reg <= k;
    cnt_reg <= (sys_rst || load_strobe) ? 3'h0 : cnt_reg + {2'h0, k && !k_reg};
  end
  property p_mode; t |=> s == $past(serial_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_hold; s && $rose(k) |-> $stable(gain_code_lsb_or_serial_data_pin); endproperty
  a_hold: assert property (p_hold) else $error("data");
  property p_gate; s && $rose(k) |-> !load_strobe; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_idle; s && load_strobe |-> !k; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_four; s && $rose(load_strobe) |-> cnt_reg == 3'h4; endproperty
  a_four: assert property (p_four) else $error("count");
  property p_ser; t && serial_mode |-> ##[30:52] $rose(load_strobe) ##[1:8] done; endproperty
  a_ser: assert property (p_ser) else $error("ser");
  property p_par; t && !serial_mode |-> ##[4:16] $fell(load_strobe) ##[1:8] done; endproperty
  a_par: assert property (p_par) else $error("par");
  property p_end; done |-> !load_strobe; endproperty
  a_end: assert property (p_end) else $error("end");
endmodule // gain_code_host_properties

// ### gain_code_host_tb.sv
// testbench for the gain code host
`timescale 1ns/10ps
module gain_code_host_tb;
  reg mclk = 1'b0, sys_rst = 1'b1, serial_mode = 1'b0, req_valid = 1'b0;
  reg [3:0] req_code = 4'h0;
  wire req_ready, done, interface_select, load_strobe, gain_code_msb_pin, gain_code_bit2_pin;
  wire gain_code_or_serial_clock_pin_a, gain_code_lsb_or_serial_data_pin;
  wire [3:0] gain;
  integer failures = 0, cmp_count = 0, i, n;
  always #4 mclk = ~mclk;
  gain_code_host i_gain_code_host (
    .mclk                             (mclk),
    .sys_rst                          (sys_rst),
    .serial_mode                      (serial_mode),
    .req_valid                        (req_valid),
    .req_code                         (req_code),
    .req_ready                        (req_ready),
    .done                             (done),
    .interface_select                 (interface_select),
    .load_strobe                      (load_strobe),
    .gain_code_msb_pin                (gain_code_msb_pin),
    .gain_code_bit2_pin               (gain_code_bit2_pin),
    .gain_code_or_serial_clock_pin_a  (gain_code_or_serial_clock_pin_a),
    .gain_code_lsb_or_serial_data_pin (gain_code_lsb_or_serial_data_pin)
  );
  gain_dev_model i_gain_dev_model (
    .interface_select (interface_select),
    .load_strobe      (load_strobe),
    .pins             ({gain_code_msb_pin, gain_code_bit2_pin,
                        gain_code_or_serial_clock_pin_a, gain_code_lsb_or_serial_data_pin}),
    .gain_reg         (gain)
  );
  task finish_test;
    begin
      $display("failures %0d cmp_count %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task check_code(input [3:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (gain !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED %0t gain %h", $time, gain);
      end
    end
  endtask
  // bounded wait: ready when sel low, done when high
  task wait_for(input sel);
    for (n = 0; (sel ? done : req_ready) !== 1'b1; n = n + 1) begin
      if (n > 99) begin
        failures = failures + 1;
        finish_test;
      end
      @(posedge mclk);
      #1;
    end
  endtask
  task load(input ser, input [3:0] code);
    begin
      wait_for(1'b0);
      serial_mode = ser;
      req_code = code;
      req_valid = 1'b1;
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      wait_for(1'b1);
      check_code(code);
    end
  endtask
  task par_all;
    for (i = 0; i < 16; i = i + 1) load(1'b0, i[3:0]);
  endtask
  task ser_all;
    for (i = 15; i >= 0; i = i - 1) load(1'b1, i[3:0]);
  endtask
  // reset mid-frame, strobe high with zero word gives minimum gain
  task mid_reset;
    begin
      load(1'b0, 4'h6);
      wait_for(1'b0);
      serial_mode = 1'b1;
      req_valid = 1'b1;
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      check_code(4'h6);
      sys_rst = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      check_code(4'h0);
      load(1'b1, 4'ha);
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    check_code(4'h0);
    par_all;
    ser_all;
    mid_reset;
    finish_test;
  end
endmodule // gain_code_host_tb
bind gain_code_host gain_code_host_properties i_props (
  .mclk                             (mclk),
  .sys_rst                          (sys_rst),
  .serial_mode                      (serial_mode),
  .req_valid                        (req_valid),
  .req_ready                        (req_ready),
  .done                             (done),
  .interface_select                 (interface_select),
  .load_strobe                      (load_strobe),
  .gain_code_or_serial_clock_pin_a  (gain_code_or_serial_clock_pin_a),
  .gain_code_lsb_or_serial_data_pin (gain_code_lsb_or_serial_data_pin)
);

// ### gain_ctrl_defs.vh
// constants for the gain code host controller
`ifndef GAIN_CTRL_DEFS_VH
`define GAIN_CTRL_DEFS_VH
`define CODE_W        4
`define CODE_MIN      4'h0
`define CODE_MAX      4'hf
`define SER_BITS      3'h4
`define DIV_W         4
`define DIV_HALF      4'h3
`define BITS_NONE     3'h0
`define BIT_STEP      3'h1
`define PIN_DATA      1'h0
`define PIN_CLK       1'h1
`endif

// ### gain_dev_model.sv
// amplifier gain control pins model
`timescale 1ns/10ps
module gain_dev_model (
  input wire       interface_select,
  input wire       load_strobe,
  input wire [3:0] pins,
  output reg [3:0] gain_reg
);
  reg [3:0] shift_reg;
  reg       strobe_seen = 1'b0;
  always @(posedge pins[1])
    if (interface_select && !load_strobe) shift_reg <= {shift_reg[2:0], pins[0]};
  // one process owns the latch; a change to parallel mode while strobe is high loads the pins into it
  always @(interface_select or load_strobe or pins) begin
    if (interface_select) begin
      if (load_strobe && !strobe_seen) gain_reg = shift_reg;
    end else if (load_strobe) begin
      gain_reg = pins;
    end
    strobe_seen = load_strobe;
  end
endmodule // gain_dev_model

// ### half_bit_divider.v
// divider making one-cycle enable pulses for link pin pacing
`timescale 1ns/10ps
`include "gain_ctrl_defs.vh"
module half_bit_divider (
  input  wire mclk,
  input  wire sys_rst,
  input  wire run,
  output reg  tick
);
  reg [`DIV_W-1:0] cnt_reg;
  always @(posedge mclk) begin
    if (sys_rst || !run) begin
      cnt_reg <= {`DIV_W{1'b0}};
      tick    <= 1'b0;
    end else if (cnt_reg == `DIV_HALF) begin
      cnt_reg <= {`DIV_W{1'b0}};
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(`DIV_W-1){1'b0}}, 1'b1};
      tick    <= 1'b0;
    end
  end
endmodule // half_bit_divider
